// ===== verif/bit_source.sv
`timescale 1ns/100ps

// ==========================================================================
// fabric logic feeding serial bits
module bit_source (
  input wire logic core_clk, // system clock
  input wire logic stall,    // hold back new offers
  input wire logic in_ready, // buffer can take
  output logic     in_valid, // bit offered
  output logic     in_data   // offered bit
);
  logic taken;

  initial begin
    in_valid = 1'b0;
    in_data  = 1'b0;
  end

  // keep an offer until taken, then maybe offer again
  always @(posedge core_clk) begin
    taken = in_valid && in_ready;
    #1;
    if (!in_valid || taken) begin
      in_valid = !stall && ($urandom_range(3) != 0);
      in_data  = in_valid ? 1'($urandom_range(1)) : ~in_data;
    end
  end
endmodule

// ===== verif/shift_chain_monitor.sv
`timescale 1ns/100ps

// ==========================================================================
// port checker for the addressable shift chain
module shift_chain_monitor #(
  parameter int FEED_DEPTH = 8
) (
  input wire logic                        core_clk,    // system clock
  input wire logic                        rst_b,       // sync reset, low
  input wire logic                        shift_en,    // clock enable
  input wire logic                        in_valid,    // bit offered
  input wire logic                        in_data,     // offered bit
  input wire logic                        in_ready,    // feed can accept
  input wire addr_shift_pkg::chain_addr_t rd_addr,     // stage select
  input wire logic                        use_out_ff,  // registered pick
  input wire logic                        async_q,     // mux output
  input wire logic                        sync_q,      // flop output
  input wire logic                        data_out,    // chosen read
  input wire logic                        cascade_out, // last stage
  input wire logic                        shifted,     // shift this cycle
  input wire logic [$clog2(FEED_DEPTH):0] feed_level,  // buffered bits
  input wire logic                        chain_primed // stages loaded
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  // shift followed by a one-step address walk
  sequence s_shift_step;
    shifted && chain_primed && rd_addr != 7'h7F
      ##1 rd_addr == $past(rd_addr) + 7'h01;
  endsequence

  property p_shift_cause;
    shifted |-> shift_en && feed_level != 0;
  endproperty
  property p_level_step;
    shifted |=> feed_level ==
      $past(feed_level) + $past(in_valid && in_ready) - 1;
  endproperty
  property p_ripple;
    s_shift_step |-> async_q == $past(async_q);
  endproperty
  property p_cascade;
    shifted && chain_primed && rd_addr == 7'h7E
      |=> cascade_out == $past(async_q);
  endproperty
  property p_sync_take;
    shifted && chain_primed |=> sync_q == $past(async_q);
  endproperty
  property p_sync_hold;
    !shifted && chain_primed |=> sync_q == $past(sync_q);
  endproperty
  property p_tail_hold;
    !shifted && chain_primed |=> cascade_out == $past(cascade_out);
  endproperty
  property p_out_pick;
    chain_primed |-> data_out == (use_out_ff ? sync_q : async_q);
  endproperty

  a_shift_cause: assert property (p_shift_cause)
    else $error("shift without enable or data");
  a_level_step: assert property (p_level_step)
    else $error("feed level off after shift");
  a_ripple: assert property (p_ripple)
    else $error("bit did not move up one stage");
  a_cascade: assert property (p_cascade)
    else $error("cascade missed stage below");
  a_sync_take: assert property (p_sync_take)
    else $error("flop missed mux value");
  a_sync_hold: assert property (p_sync_hold)
    else $error("flop moved without shift");
  a_tail_hold: assert property (p_tail_hold)
    else $error("chain moved without shift");
  a_out_pick: assert property (p_out_pick)
    else $error("output pick wrong");
endmodule

bind addressable_shift_register shift_chain_monitor #(
  .FEED_DEPTH(FEED_DEPTH)
) u_mon (
  .core_clk(core_clk), .rst_b(rst_b), .shift_en(shift_en),
  .in_valid(in_valid), .in_data(in_data), .in_ready(in_ready),
  .rd_addr(rd_addr), .use_out_ff(use_out_ff), .async_q(async_q),
  .sync_q(sync_q), .data_out(data_out), .cascade_out(cascade_out),
  .shifted(shifted), .feed_level(feed_level),
  .chain_primed(chain_primed)
);

// ===== verif/tb_top.sv
`timescale 1ns/100ps

// ==========================================================================
// bench top with reference model
module tb_top;
  logic                        core_clk = 1'b0;
  logic                        rst_b, shift_en, use_out_ff, stall, chk;
  addr_shift_pkg::chain_addr_t rd_addr;
  logic                        in_valid, in_data, in_ready, async_q;
  logic                        sync_q, data_out, cascade_out, shifted;
  logic                        chain_primed, pu, msync;
  logic [3:0]                  feed_level;
  logic                        mchain [128];
  logic                        q [$];
  int                          mcount, miscompares, checked, i;

  always #4 core_clk = ~core_clk;

  addressable_shift_register DUT (
    .core_clk(core_clk), .rst_b(rst_b), .shift_en(shift_en),
    .in_valid(in_valid), .in_data(in_data), .in_ready(in_ready),
    .rd_addr(rd_addr), .use_out_ff(use_out_ff), .async_q(async_q),
    .sync_q(sync_q), .data_out(data_out), .cascade_out(cascade_out),
    .shifted(shifted), .feed_level(feed_level),
    .chain_primed(chain_primed)
  );

  bit_source u_src (
    .core_clk(core_clk), .stall(stall), .in_ready(in_ready),
    .in_valid(in_valid), .in_data(in_data)
  );

  // ========================================================================
  // tasks
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) begin
      @(posedge core_clk);
      #1;
    end
  endtask

  task automatic results;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ========================================================================
  // reference model: buffer queue, stages never cleared
  always @(posedge core_clk) begin
    if (!rst_b) begin
      q.delete();
      msync = 1'b0;
      mcount = 0;
    end else begin
      pu = in_valid && q.size() < 8;
      if (shift_en && q.size() > 0) begin
        msync = mchain[rd_addr];
        for (int k = 127; k > 0; k--) mchain[k] = mchain[k-1];
        mchain[0] = q.pop_front();
        mcount++;
      end
      if (pu) q.push_back(in_data);
    end
  end

  // compare every output once per cycle
  always @(negedge core_clk) begin
    if (chk) begin
      check(in_ready, q.size() < 8);
      check(feed_level, 8'(q.size()));
      check(shifted, shift_en && q.size() > 0);
      check(async_q, mchain[rd_addr]);
      check(cascade_out, mchain[127]);
      check(sync_q, msync);
      check(data_out, use_out_ff ? msync : mchain[rd_addr]);
      check(chain_primed, mcount >= 128);
    end
  end

  // hang guard
  initial begin
    #200000;
    miscompares++;
    results();
  end

  // ========================================================================
  // main sequence
  initial begin
    rst_b = 1'b0;
    shift_en = 1'b0;
    use_out_ff = 1'b0;
    stall = 1'b1;
    chk = 1'b0;
    rd_addr = 7'h00;
    miscompares = 0;
    checked = 0;
    void'($urandom(17));
    step(1);
    chk = 1'b1;
    step(5);
    rst_b = 1'b1;
    // fill until refused, then drain past empty
    stall = 1'b0;
    step(14);
    stall = 1'b1;
    shift_en = 1'b1;
    step(12);
    // prime the whole chain reading stage zero
    stall = 1'b0;
    step(260);
    // random traffic, addresses and read path
    repeat (300) begin
      shift_en = 1'($urandom_range(1));
      rd_addr = 7'($urandom);
      use_out_ff = 1'($urandom_range(1));
      stall = ($urandom_range(3) == 0);
      step(1);
    end
    // address walks up with the shifting data
    shift_en = 1'b1;
    stall = 1'b0;
    for (i = 0; i < 128; i++) begin
      rd_addr = 7'(i);
      step(1);
    end
    // address alone changes the output, no edge
    shift_en = 1'b0;
    step(2);
    for (i = 0; i < 128; i++) begin
      step(1);
      rd_addr = 7'(i);
      #2;
      check(async_q, mchain[i]);
    end
    // flop as final stage behind stage 126
    step(1);
    use_out_ff = 1'b1;
    rd_addr = 7'h7E;
    shift_en = 1'b1;
    step(3);
    repeat (30) begin
      step(1);
      check(data_out, mchain[127]);
    end
    // reset in mid-run keeps the stages
    shift_en = 1'b0;
    stall = 1'b1;
    rst_b = 1'b0;
    step(6);
    rst_b = 1'b1;
    repeat (40) begin
      rd_addr = 7'($urandom);
      use_out_ff = 1'($urandom_range(1));
      step(1);
      check(async_q, mchain[rd_addr]);
    end
    results();
  end
endmodule

// ===== verilog/addr_shift_consts.svh
`ifndef ADDR_SHIFT_CONSTS_SVH
`define ADDR_SHIFT_CONSTS_SVH

// ==========================================================================
// cell geometry
`define CELL_STAGES    16
`define CELL_ADDR_W    4

// ==========================================================================
// tile geometry
`define TILE_CELLS     8
`define CHAIN_STAGES   128
`define CHAIN_ADDR_W   7
`define SEL_A_BIT      4
`define SEL_B_BIT      5
`define SEL_C_BIT      6

// ==========================================================================
// feed buffer
`define FEED_DEPTH     8
`define FEED_WIDTH     1

// ==========================================================================
// reset values of control state
`define OUT_FF_RST     1'h0
`define FILL_RST       8'h00

`endif

// ===== verilog/addr_shift_pkg.sv
`include "addr_shift_consts.svh"

// ==========================================================================
// shared types
package addr_shift_pkg;
  typedef logic [`CELL_ADDR_W-1:0]  cell_addr_t;
  typedef logic [`CHAIN_ADDR_W-1:0] chain_addr_t;
  typedef logic [`TILE_CELLS-1:0]   cell_bits_t;
  typedef logic [`CHAIN_ADDR_W:0]   fill_count_t;
endpackage

// ===== verilog/addressable_shift_register.sv
`timescale 1ns/100ps
`include "addr_shift_consts.svh"

// ==========================================================================
// addressable shift chain of one logic tile

module addressable_shift_register #(
  parameter int FEED_W     = `FEED_WIDTH,
  parameter int FEED_DEPTH = `FEED_DEPTH
) (
  input  wire logic                          core_clk,    // system clock
  input  wire logic                          rst_b,       // sync reset, low
  input  wire logic                          shift_en,    // clock enable
  input  wire logic                          in_valid,    // serial bit valid
  input  wire logic                          in_data,     // serial bit
  output logic                               in_ready,    // feed can accept
  input  wire addr_shift_pkg::chain_addr_t   rd_addr,     // stage select
  input  wire logic                          use_out_ff,  // pick registered
  output logic                               async_q,     // mux output
  output logic                               sync_q,      // flip-flop output
  output logic                               data_out,    // chosen read
  output logic                               cascade_out, // last chain stage
  output logic                               shifted,     // shift this cycle
  output logic [$clog2(FEED_DEPTH):0]        feed_level,  // buffered bits
  output logic                               chain_primed // all stages loaded
);

  // ========================================================================
  // local sizes
  localparam int CELLS  = `TILE_CELLS;
  localparam int STAGES = `CELL_STAGES;
  localparam int NA     = CELLS / 2;
  localparam int NB     = CELLS / 4;

  // ========================================================================
  // declarations
  feed_stream_if #(.WIDTH(FEED_W)) feed ();

  addr_shift_pkg::cell_bits_t  cell_q;
  addr_shift_pkg::cell_bits_t  cell_casc;
  addr_shift_pkg::cell_bits_t  cell_in;
  addr_shift_pkg::cell_addr_t  cell_addr;
  logic [NA-1:0]               wide_select_stage_a;
  logic [NB-1:0]               wide_select_stage_b;
  logic                        wide_select_stage_c;
  logic                        shift_fire;
  logic                        ser_bit;
  logic                        sync_q_reg, sync_q_next;
  addr_shift_pkg::fill_count_t fill_reg, fill_next;

  // ========================================================================
  // helper functions

  // two-way select used at every wide mux level
  function automatic logic mux2(input logic lo, input logic hi,
                                input logic sel);
    mux2 = sel ? hi : lo;
  endfunction

  // address of the stage within one cell
  function automatic addr_shift_pkg::cell_addr_t cell_part(
    input addr_shift_pkg::chain_addr_t a);
    cell_part = a[`CELL_ADDR_W-1:0];
  endfunction

  // saturating increment of the fill count
  function automatic addr_shift_pkg::fill_count_t fill_step(
    input addr_shift_pkg::fill_count_t c);
    if (c == addr_shift_pkg::fill_count_t'(`CHAIN_STAGES)) begin
      fill_step = c;
    end else begin
      fill_step = c + 1'b1;
    end
  endfunction

  // ========================================================================
  // feed buffer

  // bits wait here until the enable lets the chain take them
  feed_fifo #(
    .WIDTH (FEED_W),
    .DEPTH (FEED_DEPTH)
  ) u_feed (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .in_valid (in_valid),
    .in_ready (in_ready),
    .in_data  (FEED_W'(in_data)),
    .out      (feed.src),
    .level    (feed_level)
  );

  // ========================================================================
  // shift control

  // chain moves only on an enabled edge with a bit ready
  assign feed.ready = shift_en;                          // stall when off
  assign shift_fire = shift_en & feed.valid;
  assign ser_bit    = feed.data[0];
  assign shifted    = shift_fire;

  // ========================================================================
  // cell chain

  // first cell takes the serial bit, the rest take the cascade
  always_comb begin
    cell_in = '0;
    cell_in[0] = ser_bit;
    for (int i = 1; i < CELLS; i++) begin
      cell_in[i] = cell_casc[i-1];
    end
  end

  // all cells share the low address bits
  assign cell_addr = cell_part(rd_addr);

  // one instance per sixteen stages
  for (genvar g = 0; g < CELLS; g++) begin : g_cell
    shift_cell #(
      .STAGES (STAGES)
    ) u_cell (
      .core_clk    (core_clk),
      .shift_en    (shift_fire),
      .ser_in      (cell_in[g]),
      .addr        (cell_addr),
      .q           (cell_q[g]),
      .cascade_out (cell_casc[g])
    );
  end

  // chain end leaves on its own path, not through the address mux
  assign cascade_out = cell_casc[CELLS-1];

  // ========================================================================
  // wide output multiplexers

  // first level joins cell pairs
  always_comb begin
    wide_select_stage_a = '0;
    for (int i = 0; i < NA; i++) begin
      wide_select_stage_a[i] = mux2(cell_q[2*i], cell_q[2*i+1],
                                    rd_addr[`SEL_A_BIT]);
    end
  end

  // second level joins pairs of pairs
  always_comb begin
    wide_select_stage_b = '0;
    for (int i = 0; i < NB; i++) begin
      wide_select_stage_b[i] = mux2(wide_select_stage_a[2*i],
                                    wide_select_stage_a[2*i+1],
                                    rd_addr[`SEL_B_BIT]);
    end
  end

  // last level covers the whole tile
  always_comb begin
    wide_select_stage_c = mux2(wide_select_stage_b[0],
                               wide_select_stage_b[1],
                               rd_addr[`SEL_C_BIT]);
  end

  // address change shows at once, no clock in the path
  assign async_q = wide_select_stage_c;

  // ========================================================================
  // optional output flip-flop

  // captures the mux under the same enable as the chain
  always_comb begin
    sync_q_next = sync_q_reg;
    if (shift_fire) begin
      sync_q_next = async_q;
    end
  end

  // control flop, cleared so the output is defined from reset
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      sync_q_reg <= `OUT_FF_RST;
    end else begin
      sync_q_reg <= sync_q_next;
    end
  end

  // the flop acts as an extra stage only while the address stays fixed
  assign sync_q   = sync_q_reg;
  assign data_out = use_out_ff ? sync_q_reg : async_q;

  // ========================================================================
  // fill tracking

  // counts shifts until every stage has seen a defined bit
  always_comb begin
    fill_next = fill_reg;
    if (shift_fire) begin
      fill_next = fill_step(fill_reg);
    end
  end

  // count is control state; the stages themselves stay uncleared
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      fill_reg <= addr_shift_pkg::fill_count_t'(`FILL_RST);
    end else begin
      fill_reg <= fill_next;
    end
  end

  // high once the whole chain holds shifted-in data
  assign chain_primed =
    (fill_reg == addr_shift_pkg::fill_count_t'(`CHAIN_STAGES));

endmodule

// ===== verilog/feed_fifo.sv
`timescale 1ns/100ps
`include "addr_shift_consts.svh"

// ==========================================================================
// feed buffer ahead of the shift chain
module feed_fifo #(
  parameter int WIDTH = `FEED_WIDTH,
  parameter int DEPTH = `FEED_DEPTH
) (
  input  wire logic             core_clk,  // system clock
  input  wire logic             rst_b,     // sync reset, active low
  input  wire logic             in_valid,  // source has a word
  output logic                  in_ready,  // buffer can take a word
  input  wire logic [WIDTH-1:0] in_data,   // word from source
  feed_stream_if.src            out,       // drain side
  output logic [$clog2(DEPTH):0] level     // words held
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr_reg, wr_ptr_next;
  logic [PW-1:0]    rd_ptr_reg, rd_ptr_next;
  logic [PW:0]      count_reg, count_next;
  logic             push, pop;

  // handshake terms
  assign in_ready  = (count_reg != (PW+1)'(DEPTH));
  assign out.valid = (count_reg != '0);
  assign out.data  = mem[rd_ptr_reg];
  assign push      = in_valid & in_ready;
  assign pop       = out.valid & out.ready;
  assign level     = count_reg;

  // pointer and count update
  always_comb begin
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    count_next  = count_reg;
    if (push) begin
      wr_ptr_next = (wr_ptr_reg == PW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
    end
    if (pop) begin
      rd_ptr_next = (rd_ptr_reg == PW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
    end
    if (push && !pop) begin
      count_next = count_reg + 1'b1;
    end else if (pop && !push) begin
      count_next = count_reg - 1'b1;
    end
  end

  // registers
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg  <= count_next;
    end
  end

  // storage, no reset needed
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end
endmodule

// ===== verilog/feed_stream_if.sv
`timescale 1ns/100ps

// ==========================================================================
// valid/ready stream between feed buffer and shift logic
interface feed_stream_if #(
  parameter int WIDTH = 1
);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ===== verilog/shift_cell.sv
`timescale 1ns/100ps
`include "addr_shift_consts.svh"

// ==========================================================================
// one sixteen-stage addressable cell
module shift_cell #(
  parameter int STAGES = `CELL_STAGES
) (
  input  wire logic                       core_clk,    // system clock
  input  wire logic                       shift_en,    // clock enable
  input  wire logic                       ser_in,      // serial input
  input  wire logic [$clog2(STAGES)-1:0]  addr,        // stage select
  output logic                            q,           // addressed stage
  output logic                            cascade_out  // last stage
);
  logic [STAGES-1:0] stages_reg;
  logic [STAGES-1:0] stages_next;

  // shift toward the top, new bit in stage zero
  always_comb begin
    stages_next = stages_reg;
    if (shift_en) begin
      stages_next = {stages_reg[STAGES-2:0], ser_in};
    end
  end

  // storage has no set or reset
  always_ff @(posedge core_clk) begin
    stages_reg <= stages_next;
  end

  // asynchronous read and dedicated cascade
  assign q           = stages_reg[addr];
  assign cascade_out = stages_reg[STAGES-1];
endmodule
